// [rtl/byte_bit_instruction_exec.sv]
// instruction-cycle sequencer executing add/and, bit set/clear and bit-test skip
`timescale 1ns/1ps
module byte_bit_instruction_exec
(
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      instr_valid,
  input  wire logic [exec_pkg::IW-1:0]   instr_word,
  output logic                           instr_take,
  output logic      [exec_pkg::AW-1:0]   file_addr,
  input  wire logic [exec_pkg::DW-1:0]   file_rdata,
  output logic      [exec_pkg::DW-1:0]   file_wdata,
  output logic                           file_we,
  output logic      [exec_pkg::DW-1:0]   acc_out,
  output logic                           carry_flag,
  output logic                           digit_carry_flag,
  output logic                           zero_flag,
  output logic                           skip_nop
);
  typedef struct packed {
    exec_pkg::phase_e          phase;
    exec_pkg::op_e             op;
    logic [exec_pkg::IW-1:0]   instr;
    logic [exec_pkg::AW-1:0]   addr;
    logic [exec_pkg::DW-1:0]   rdata;
    logic [exec_pkg::DW-1:0]   wdata;
    logic                      we;
    logic [exec_pkg::DW-1:0]   acc;
    logic                      c;
    logic                      dig_c;
    logic                      z;
    logic                      skip;
    logic                      nop;
  } state_s;

  state_s q_q;
  state_s d_d;

  logic [exec_pkg::DW-1:0] lit;
  logic [exec_pkg::BW-1:0] bpos;
  logic                    dest;
  logic [exec_pkg::DW-1:0] operand;
  logic [exec_pkg::DW-1:0] alu_res;
  logic                    alu_c;
  logic                    alu_digit;
  logic                    alu_z;
  logic                    alu_bit;

  assign lit     = q_q.instr[exec_pkg::LIT_LSB +: exec_pkg::DW];
  assign bpos    = q_q.instr[exec_pkg::BPOS_LSB +: exec_pkg::BW];
  assign dest    = q_q.instr[exec_pkg::DEST_POS];
  assign operand = (q_q.op == exec_pkg::OP_ADD_LIT || q_q.op == exec_pkg::OP_AND_LIT)
                   ? lit : q_q.rdata;

  exec_alu u_alu
  (
    .op          (q_q.op),
    .acc         (q_q.acc),
    .operand     (operand),
    .bit_pos     (bpos),
    .result      (alu_res),
    .carry       (alu_c),
    .digit_carry (alu_digit),
    .zero        (alu_z),
    .bit_val     (alu_bit)
  );

  // instruction is offered in Q1, file byte read in Q2, executed in Q3, written in Q4
  always_comb
  begin
    d_d    = q_q;
    d_d.we = 1'b0;
    unique case (q_q.phase)
      exec_pkg::PH_Q1:
      begin
        d_d.phase = exec_pkg::PH_Q2;
        d_d.op    = exec_pkg::OP_NONE;
        // a discarded instruction is still consumed so the fetch stream stays aligned
        if (instr_valid && !q_q.nop)
        begin
          d_d.op    = exec_pkg::decode(instr_word);
          d_d.instr = instr_word;
          d_d.addr  = instr_word[exec_pkg::ADDR_LSB +: exec_pkg::AW];
        end
      end
      exec_pkg::PH_Q2:
      begin
        d_d.phase = exec_pkg::PH_Q3;
        d_d.rdata = file_rdata;
      end
      exec_pkg::PH_Q3:
      begin
        d_d.phase = exec_pkg::PH_Q4;
        unique case (q_q.op)
          exec_pkg::OP_ADD_LIT, exec_pkg::OP_ADD_F:
          begin
            d_d.c  = alu_c;
            d_d.dig_c = alu_digit;
            d_d.z  = alu_z;
          end
          exec_pkg::OP_AND_LIT, exec_pkg::OP_AND_F:
            d_d.z = alu_z;
          default:
            d_d.z = q_q.z;
        endcase
        unique case (q_q.op)
          exec_pkg::OP_ADD_LIT, exec_pkg::OP_AND_LIT:
            d_d.acc = alu_res;
          exec_pkg::OP_ADD_F, exec_pkg::OP_AND_F:
          begin
            if (dest == exec_pkg::DEST_ACC)
              d_d.acc = alu_res;
            else
            begin
              d_d.wdata = alu_res;
              d_d.we    = 1'b1;
            end
          end
          exec_pkg::OP_BIT_CLR, exec_pkg::OP_BIT_SET:
          begin
            d_d.wdata = alu_res;
            d_d.we    = 1'b1;
          end
          exec_pkg::OP_SKIP_ONE:
            d_d.skip = alu_bit;
          exec_pkg::OP_SKIP_ZERO:
            d_d.skip = !alu_bit;
          default:
            d_d.skip = 1'b0;
        endcase
      end
      exec_pkg::PH_Q4:
      begin
        d_d.phase = exec_pkg::PH_Q1;
        d_d.nop   = q_q.skip;
        d_d.skip  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      q_q <= '0;
    else
      q_q <= d_d;
  end

  assign instr_take       = (q_q.phase == exec_pkg::PH_Q1);
  assign file_addr        = q_q.addr;
  assign file_wdata       = q_q.wdata;
  assign file_we          = q_q.we;
  assign acc_out          = q_q.acc;
  assign carry_flag       = q_q.c;
  assign digit_carry_flag = q_q.dig_c;
  assign zero_flag        = q_q.z;
  assign skip_nop         = q_q.nop;

  // reference values for the checks below
  logic [exec_pkg::DW:0]        ref_sum;
  logic [exec_pkg::NIB_BIT+1:0] ref_low;
  logic                         in_q3;
  logic [exec_pkg::DW-1:0]      ref_mask;

  assign ref_sum  = {1'b0, q_q.acc} + {1'b0, operand};
  assign ref_low  = {1'b0, q_q.acc[exec_pkg::NIB_BIT:0]} + {1'b0, operand[exec_pkg::NIB_BIT:0]};
  assign in_q3    = (q_q.phase == exec_pkg::PH_Q3);
  assign ref_mask = exec_pkg::DW'(1) << bpos;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence skip_one_hit;
    in_q3 && q_q.op == exec_pkg::OP_SKIP_ONE && q_q.rdata[bpos];
  endsequence
  sequence skip_zero_hit;
    in_q3 && q_q.op == exec_pkg::OP_SKIP_ZERO && !q_q.rdata[bpos];
  endsequence
  sequence nop_cycle;
    skip_nop[*4] ##1 !skip_nop;
  endsequence

  add_literal_a: assert property (in_q3 && q_q.op == exec_pkg::OP_ADD_LIT |=>
    acc_out == $past(ref_sum[exec_pkg::DW-1:0]) && carry_flag == $past(ref_sum[exec_pkg::DW]))
    else $error("literal add result or carry wrong");
  and_literal_a: assert property (in_q3 && q_q.op == exec_pkg::OP_AND_LIT |=>
    acc_out == ($past(q_q.acc) & $past(lit)) && $stable(carry_flag) && $stable(digit_carry_flag))
    else $error("literal and result or flags wrong");
  add_file_flags_a: assert property (in_q3 && q_q.op == exec_pkg::OP_ADD_F |=>
    carry_flag == $past(ref_sum[exec_pkg::DW])
    && digit_carry_flag == $past(ref_low[exec_pkg::NIB_BIT+1]))
    else $error("file add carry flags wrong");
  and_file_flags_a: assert property (in_q3 && q_q.op == exec_pkg::OP_AND_F |=>
    $stable(carry_flag) && $stable(digit_carry_flag)
    && zero_flag == (($past(q_q.acc) & $past(q_q.rdata)) == '0))
    else $error("file and flags wrong");
  dest_select_a: assert property (in_q3 && (q_q.op == exec_pkg::OP_ADD_F
    || q_q.op == exec_pkg::OP_AND_F) |=> file_we == $past(dest) ##1 !file_we)
    else $error("destination select wrong");
  bit_clear_a: assert property (in_q3 && q_q.op == exec_pkg::OP_BIT_CLR |=>
    file_we && file_wdata == ($past(q_q.rdata) & ~$past(ref_mask)) && $stable(zero_flag))
    else $error("bit clear wrong");
  bit_set_a: assert property (in_q3 && q_q.op == exec_pkg::OP_BIT_SET |=>
    file_we && file_wdata == ($past(q_q.rdata) | $past(ref_mask)) && $stable(carry_flag))
    else $error("bit set wrong");
  skip_one_a: assert property (skip_one_hit |-> ##2 nop_cycle)
    else $error("skip on one did not give a no-op cycle");
  skip_zero_a: assert property (skip_zero_hit |-> ##2 nop_cycle)
    else $error("skip on zero did not give a no-op cycle");
  no_skip_a: assert property (in_q3 && q_q.op == exec_pkg::OP_SKIP_ONE && !q_q.rdata[bpos]
    |-> ##2 !skip_nop)
    else $error("spurious skip");
  cycle_len_a: assert property (instr_take |=> !instr_take[*3] ##1 instr_take)
    else $error("instruction cycle not four clocks");
  nop_quiet_a: assert property (skip_nop |-> !file_we && $stable(acc_out))
    else $error("discarded cycle changed state");
  zero_flag_a: assert property (in_q3 && q_q.op == exec_pkg::OP_ADD_LIT |=>
    zero_flag == (acc_out == '0))
    else $error("zero flag wrong");
endmodule : byte_bit_instruction_exec

// [rtl/exec_alu.sv]
// combinational arithmetic and bit logic for the execution block
`timescale 1ns/1ps
module exec_alu
(
  input  wire exec_pkg::op_e             op,
  input  wire logic [exec_pkg::DW-1:0]   acc,
  input  wire logic [exec_pkg::DW-1:0]   operand,
  input  wire logic [exec_pkg::BW-1:0]   bit_pos,
  output logic      [exec_pkg::DW-1:0]   result,
  output logic                           carry,
  output logic                           digit_carry,
  output logic                           zero,
  output logic                           bit_val
);
  logic [exec_pkg::DW:0]   sum;
  logic [exec_pkg::NIB_BIT+1:0] low_sum;
  logic [exec_pkg::DW-1:0] mask;

  always_comb
  begin
    sum     = {1'b0, acc} + {1'b0, operand};
    low_sum = {1'b0, acc[exec_pkg::NIB_BIT:0]} + {1'b0, operand[exec_pkg::NIB_BIT:0]};
    mask    = exec_pkg::DW'(1) << bit_pos;
    bit_val = operand[bit_pos];
    result  = operand;
    unique case (op)
      exec_pkg::OP_ADD_LIT, exec_pkg::OP_ADD_F: result = sum[exec_pkg::DW-1:0];
      exec_pkg::OP_AND_LIT, exec_pkg::OP_AND_F: result = acc & operand;
      exec_pkg::OP_BIT_CLR: result = operand & ~mask;
      exec_pkg::OP_BIT_SET: result = operand | mask;
      default: result = operand;
    endcase
    carry       = sum[exec_pkg::DW];
    digit_carry = low_sum[exec_pkg::NIB_BIT+1];
    zero        = (result == '0);
  end
endmodule : exec_alu

// [rtl/exec_pkg.sv]
// shared widths, opcode fields, encodings and states of the byte/bit execution block
package exec_pkg;
  localparam int unsigned IW = 14;
  localparam int unsigned DW = 8;
  localparam int unsigned AW = 7;
  localparam int unsigned BW = 3;
  localparam int unsigned PHASES_PER_CYCLE = 4;

  // field positions inside the instruction word
  localparam int unsigned LIT_LSB   = 0;
  localparam int unsigned ADDR_LSB  = 0;
  localparam int unsigned DEST_POS  = 7;
  localparam int unsigned BPOS_LSB  = 7;
  localparam int unsigned BOP_LSB   = 10;
  localparam int unsigned CLASS_LSB = 12;
  localparam int unsigned NIB_BIT   = 3;

  // opcode values
  localparam logic [1:0] CLASS_BIT   = 2'h1;
  localparam logic [1:0] BOP_CLEAR   = 2'h0;
  localparam logic [1:0] BOP_SET     = 2'h1;
  localparam logic [1:0] BOP_SKIP_Z  = 2'h2;
  localparam logic [1:0] BOP_SKIP_O  = 2'h3;
  localparam logic [4:0] OPC_ADD_LIT = 5'h1F;
  localparam logic [5:0] OPC_AND_LIT = 6'h39;
  localparam logic [5:0] OPC_ADD_F   = 6'h07;
  localparam logic [5:0] OPC_AND_F   = 6'h05;
  localparam logic       DEST_ACC    = 1'h0;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;

  typedef enum logic [3:0] {
    OP_NONE, OP_ADD_LIT, OP_AND_LIT, OP_ADD_F, OP_AND_F,
    OP_BIT_CLR, OP_BIT_SET, OP_SKIP_ZERO, OP_SKIP_ONE
  } op_e;

  function automatic op_e decode(input logic [IW-1:0] w);
    op_e o;
    o = OP_NONE;
    if (w[IW-1 -: 2] == CLASS_BIT)
    begin
      unique case (w[BOP_LSB +: 2])
        BOP_CLEAR:  o = OP_BIT_CLR;
        BOP_SET:    o = OP_BIT_SET;
        BOP_SKIP_Z: o = OP_SKIP_ZERO;
        BOP_SKIP_O: o = OP_SKIP_ONE;
      endcase
    end
    else if (w[IW-1 -: 5] == OPC_ADD_LIT)
      o = OP_ADD_LIT;
    else if (w[IW-1 -: 6] == OPC_AND_LIT)
      o = OP_AND_LIT;
    else if (w[IW-1 -: 6] == OPC_ADD_F)
      o = OP_ADD_F;
    else if (w[IW-1 -: 6] == OPC_AND_F)
      o = OP_AND_F;
    return o;
  endfunction : decode
endpackage : exec_pkg

// [test/byte_bit_instruction_exec_test.sv]
// self-checking bench for the byte/bit instruction execution block
`timescale 1ns/1ps
module byte_bit_instruction_exec_test;
  typedef struct {
    logic [7:0] acc;
    logic       c;
    logic       dig_c;
    logic       z;
    logic       we;
    logic [7:0] wdata;
    logic       fop;
    logic [6:0] addr;
    logic       skip;
  } note_s;

  logic                        clk;
  logic                        rst_b;
  logic                        instr_valid;
  logic [exec_pkg::IW-1:0]     instr_word;
  logic                        instr_take;
  logic [exec_pkg::AW-1:0]     file_addr;
  logic [exec_pkg::DW-1:0]     file_rdata;
  logic [exec_pkg::DW-1:0]     file_wdata;
  logic                        file_we;
  logic [exec_pkg::DW-1:0]     acc_out;
  logic                        carry_flag;
  logic                        digit_carry_flag;
  logic                        zero_flag;
  logic                        skip_nop;
  logic [7:0]                  rf [128];
  logic [7:0]                  mm [128];
  logic [7:0]                  m_acc;
  logic                        m_c;
  logic                        m_dig_c;
  logic                        m_z;
  logic                        skip_pend;
  logic [7:0]                  rnd;
  logic                        taken;
  logic                        skip_seen;
  logic                        we_seen;
  note_s                       q [$];
  note_s                       nm;
  int                          errors;
  int                          total_checks;
  int                          cycles;
  int                          ph;

  byte_bit_instruction_exec dut_u (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_take(instr_take), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_wdata(file_wdata), .file_we(file_we), .acc_out(acc_out),
    .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
    .skip_nop(skip_nop));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // file register array seen by the block; the model keeps its own copy in mm
  assign file_rdata = rf[file_addr];
  always @(posedge clk)
  begin
    if (file_we === 1'b1)
      rf[file_addr] <= file_wdata;
    if (rst_b !== 1'b1)
      taken <= 1'b0;
    else if (instr_take === 1'b1)
      taken <= instr_valid;
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // present one word in the next take slot and note what it must do
  task automatic issue(input logic [13:0] w, input logic vld = 1'b1);
    note_s      n;
    logic [7:0] v;
    logic [7:0] r;
    logic [8:0] s;
    logic [4:0] h;
    logic       isf;
    int         i;
    i = 0;
    @(negedge clk);
    while (instr_take !== 1'b1 && i < 8)
    begin
      @(negedge clk);
      i++;
    end
    instr_valid = vld;
    instr_word = w;
    // an empty slot still runs the pending no-op cycle, so the skip is spent
    if (!vld)
    begin
      skip_pend = 1'b0;
      return;
    end
    n.we = 1'b0;
    n.fop = 1'b0;
    n.wdata = 8'h00;
    n.addr = w[6:0];
    n.skip = skip_pend;
    v = mm[w[6:0]];
    isf = (w[13:12] == 2'h0);
    r = 8'h00;
    if (skip_pend)
      skip_pend = 1'b0;
    else if (w[13:12] == 2'h1)
    begin
      n.fop = 1'b1;
      case (w[11:10])
        2'h0: v[w[9:7]] = 1'b0;
        2'h1: v[w[9:7]] = 1'b1;
        2'h2: skip_pend = ~v[w[9:7]];
        default: skip_pend = v[w[9:7]];
      endcase
      n.we = ~w[11];
      n.wdata = v;
      mm[w[6:0]] = v;
    end
    else if (w[13:9] == 5'h1F || w[13:8] == 6'h07 || w[13:8] == 6'h39 || w[13:8] == 6'h05)
    begin
      if (w[13:9] == 5'h1F || w[13:8] == 6'h07)
      begin
        s = {1'b0, m_acc} + {1'b0, isf ? v : w[7:0]};
        h = {1'b0, m_acc[3:0]} + {1'b0, isf ? v[3:0] : w[3:0]};
        m_c = s[8];
        m_dig_c = h[4];
        r = s[7:0];
      end
      else
        r = m_acc & (isf ? v : w[7:0]);
      m_z = (r == 8'h00);
      n.fop = isf;
      if (isf && w[7])
      begin
        mm[w[6:0]] = r;
        n.we = 1'b1;
        n.wdata = r;
      end
      else
        m_acc = r;
    end
    n.acc = m_acc;
    n.c = m_c;
    n.dig_c = m_dig_c;
    n.z = m_z;
    q.push_back(n);
  endtask : issue

  // the previous slot's results are all settled in the next take slot;
  // the write strobe stands only in the fourth phase, so it is caught there
  always @(negedge clk)
  begin
    if (rst_b !== 1'b1)
    begin
      ph = 0;
      skip_seen = 1'b0;
      we_seen = 1'b0;
    end
    else if (instr_take === 1'b1)
    begin
      if (taken === 1'b1 && q.size() > 0)
      begin
        nm = q.pop_front();
        check(8'(ph), 8'h03);
        check(acc_out, nm.acc);
        check({7'h00, carry_flag}, {7'h00, nm.c});
        check({7'h00, digit_carry_flag}, {7'h00, nm.dig_c});
        check({7'h00, zero_flag}, {7'h00, nm.z});
        check({7'h00, we_seen}, {7'h00, nm.we});
        check({7'h00, skip_seen}, {7'h00, nm.skip});
        if (nm.we)
          check(file_wdata, nm.wdata);
        if (nm.fop)
          check({1'b0, file_addr}, {1'b0, nm.addr});
      end
      ph = 0;
      skip_seen = 1'b0;
      we_seen = 1'b0;
    end
    else
    begin
      ph++;
      if (ph == 2)
        skip_seen = skip_nop;
      if (ph == 3)
        we_seen = file_we;
    end
  end

  initial
  begin
    rst_b = 1'b0;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    errors = 0;
    total_checks = 0;
    {m_acc, m_c, m_dig_c, m_z, skip_pend} = 12'h000;
    rnd = 8'h13;
    for (int i = 0; i < 128; i++)
    begin
      rnd = lfsr(rnd);
      rf[i] = rnd;
      mm[i] = rnd;
    end
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    // accumulator starts at zero, so these walk the carry, digit carry and zero cases
    issue({6'h3E, 8'h0F});
    issue({6'h3F, 8'h01});
    issue({6'h3E, 8'hF0});
    issue({6'h39, 8'hFF});
    issue({6'h3E, 8'hA5});
    issue({6'h39, 8'h5A});
    issue({6'h3E, 8'h99});
    issue({6'h07, 1'b0, 7'h00});
    issue({6'h07, 1'b1, 7'h7F});
    issue({6'h05, 1'b1, 7'h00});
    issue({6'h05, 1'b0, 7'h7F});
    for (int b = 0; b < 8; b++)
    begin
      issue({2'h1, 2'h1, 3'(b), 7'h10});
      issue({2'h1, 2'h0, 3'(b), 7'h11});
    end
    for (int k = 0; k < 4; k++)
    begin
      issue({2'h1, 1'b1, k[1], 3'h3, 6'h08, k[0]});
      issue({6'h3E, 8'h33});
    end
    // a dropped word that is itself a skip test must not arm another skip
    issue({2'h1, 2'h3, 3'h5, 7'h10});
    issue({2'h1, 2'h2, 3'h5, 7'h11});
    issue({6'h3E, 8'h21});
    issue(14'h0000);
    issue(14'h3000);
    issue(14'h0000, 1'b0);
    repeat (200)
    begin
      rnd = lfsr(rnd);
      h_word();
    end
    issue(14'h0000, 1'b0);
    issue(14'h0000, 1'b0);
    check(8'(q.size()), 8'h00);
    tally_and_finish();
  end

  task automatic h_word();
    logic [7:0] a;
    a = rnd;
    rnd = lfsr(rnd);
    case (a[2:0])
      3'h0: issue({5'h1F, a[3], rnd});
      3'h1: issue({6'h39, rnd});
      3'h2: issue({6'h07, a[3], rnd[6:0]});
      3'h3: issue({6'h05, a[3], rnd[6:0]});
      default: issue({2'h1, a[4:3], rnd[6:4], 4'h0, rnd[2:0]});
    endcase
  endtask : h_word
endmodule : byte_bit_instruction_exec_test
